// [dvm_pkg.sv]
// dvm_pkg: shared constants and types for the voltage transition control block.
// assumes one 100 MHz clock; the byte-level register port is fed by the device's i2c engine.
package dvm_pkg;
  localparam int DVM_CODE_W = 5;
  localparam int DVM_NSUP = 4;
  // supply indices
  localparam int DVM_CORE = 0;
  localparam int DVM_SB = 1;
  localparam int DVM_L4 = 2;
  localparam int DVM_L2 = 3;
  // register offsets and reset values
  localparam logic [7:0] DVM_ADDR_CTRL_A = 8'h20;
  localparam logic [7:0] DVM_ADDR_CTRL_B = 8'h21;
  localparam logic [7:0] DVM_CTRL_RST = 8'h00;
  // transition_ctrl_a field positions
  localparam int A_L4_SEL = 7;
  localparam int A_L4_GO = 6;
  localparam int A_L2A_SEL2 = 5;
  localparam int A_L2A_GO2 = 4;
  localparam int A_CORE_SEL1 = 3;
  localparam int A_CORE_GO1 = 2;
  localparam int A_SB_SEL1 = 1;
  localparam int A_SB_GO1 = 0;
  // transition_ctrl_b field positions
  localparam int B_L2B_SEL = 7;
  localparam int B_L2B_GO = 6;
  localparam int B_L2A_SEL1 = 5;
  localparam int B_L2A_GO1 = 4;
  localparam int B_CORE_SEL2 = 3;
  localparam int B_CORE_GO2 = 2;
  localparam int B_SB_SEL2 = 1;
  localparam int B_SB_GO2 = 0;
  // core buck default after pin enable: code 10011 is 1.200 V (0.725 V + 19 x 25 mV)
  localparam logic [4:0] DVM_CORE_DEFAULT = 5'h13;
  // cycles per code step of a ramp
  localparam int DVM_STEP_CYC = 16;

  typedef struct packed {
    logic [DVM_CODE_W-1:0] second;
    logic [DVM_CODE_W-1:0] first;
  } dvm_pair_t;

  typedef enum logic {DVM_IDLE, DVM_RAMP} dvm_state_t;
endpackage : dvm_pkg

// [dvm_ctrl.sv]
// dvm_ctrl: go/select control registers and ramp sequencing for the scaled supplies.
// assumes the i2c engine gives one-cycle byte writes on sys_clk; target codes come from
// the voltage setting registers elsewhere; core_enable_pin is asynchronous.
`timescale 1ns/1ps
module dvm_ctrl
  import dvm_pkg::*;
#(
  parameter int STEP_CYC = DVM_STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire dvm_pair_t core_target,
  input wire dvm_pair_t second_buck_target,
  input wire dvm_pair_t linreg_four_target,
  input wire dvm_pair_t linreg_two_a_target,
  input wire dvm_pair_t linreg_two_b_target,
  input wire logic core_enable_pin,
  input wire logic core_active_level,
  output logic [DVM_NSUP-1:0][DVM_CODE_W-1:0] supply_code,
  output logic [DVM_NSUP-1:0] supply_busy,
  output logic core_buck_on
);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);

  logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d, rdata_q, rdata_d;
  logic pin_s1_q, pin_s2_q, pin_prev_q, on_q, on_d;
  logic pin_fall, core_edge, wr_a, wr_b;
  logic [7:0] hold_a, hold_b, clr_a, clr_b;
  logic [DVM_NSUP-1:0] launch, done, busy_q;
  logic [DVM_NSUP-1:0][DVM_CODE_W-1:0] launch_tgt, cur_q, tgt_q;
  dvm_state_t [DVM_NSUP-1:0] st_q;
  logic [DVM_NSUP-1:0][7:0] cnt_q;

  // pin synchroniser; only the second stage and its delayed copy feed logic
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_s1_q <= core_enable_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // pin decode: buck on level, enable edge, falling edge
  always_comb begin
    on_d = (pin_s2_q == core_active_level);
    core_edge = on_d && !on_q;
    pin_fall = pin_prev_q && !pin_s2_q;
  end

  // register writes; go bits of a ramping supply, bar the linreg two a-side pair, are frozen so writes neither stop nor restart
  always_comb begin
    wr_a = reg_wr && (reg_addr == DVM_ADDR_CTRL_A);
    wr_b = reg_wr && (reg_addr == DVM_ADDR_CTRL_B);
    hold_a = '0;
    hold_b = '0;
    hold_a[A_CORE_GO1] = busy_q[DVM_CORE];
    hold_b[B_CORE_GO2] = busy_q[DVM_CORE];
    hold_a[A_SB_GO1] = busy_q[DVM_SB];
    hold_b[B_SB_GO2] = busy_q[DVM_SB];
    hold_a[A_L4_GO] = busy_q[DVM_L4];
    hold_b[B_L2B_GO] = busy_q[DVM_L2];
    clr_a = '0;
    clr_b = '0;
    clr_a[A_CORE_GO1] = done[DVM_CORE] || core_edge;
    clr_b[B_CORE_GO2] = done[DVM_CORE] || core_edge;
    clr_a[A_SB_GO1] = done[DVM_SB];
    clr_b[B_SB_GO2] = done[DVM_SB];
    clr_a[A_L4_GO] = done[DVM_L4];
    clr_b[B_L2B_GO] = done[DVM_L2];
    ctrl_a_d = wr_a ? ((reg_wdata & ~hold_a) | (ctrl_a_q & hold_a)) : ctrl_a_q;
    ctrl_b_d = wr_b ? ((reg_wdata & ~hold_b) | (ctrl_b_q & hold_b)) : ctrl_b_q;
    ctrl_a_d = ctrl_a_d & ~clr_a;
    ctrl_b_d = ctrl_b_d & ~clr_b;
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = (reg_addr == DVM_ADDR_CTRL_A) ? ctrl_a_q : (reg_addr == DVM_ADDR_CTRL_B) ? ctrl_b_q : 8'h00;
    end
  end

  // launch decode and target choice; select bits taken as they stand after this write
  always_comb begin
    launch[DVM_CORE] = !busy_q[DVM_CORE] && on_q && !core_edge
      && ((wr_a && reg_wdata[A_CORE_GO1]) || (wr_b && reg_wdata[B_CORE_GO2]));
    launch[DVM_SB] = !busy_q[DVM_SB]
      && ((wr_a && reg_wdata[A_SB_GO1]) || (wr_b && reg_wdata[B_SB_GO2]));
    launch[DVM_L4] = !busy_q[DVM_L4] && wr_a && reg_wdata[A_L4_GO];
    // a-side go bits deliberately absent here
    launch[DVM_L2] = !busy_q[DVM_L2] && ((wr_b && reg_wdata[B_L2B_GO]) || pin_fall);
    launch_tgt[DVM_CORE] = (ctrl_a_d[A_CORE_SEL1] || ctrl_b_d[B_CORE_SEL2]) ? core_target.second
      : core_target.first;
    launch_tgt[DVM_SB] = (ctrl_a_d[A_SB_SEL1] || ctrl_b_d[B_SB_SEL2]) ? second_buck_target.second
      : second_buck_target.first;
    launch_tgt[DVM_L4] = ctrl_a_d[A_L4_SEL] ? linreg_four_target.second : linreg_four_target.first;
    if (pin_fall) begin
      launch_tgt[DVM_L2] = (ctrl_a_d[A_L2A_SEL2] || ctrl_b_d[B_L2A_SEL1]) ? linreg_two_a_target.second
        : linreg_two_a_target.first;
    end else begin
      launch_tgt[DVM_L2] = ctrl_b_d[B_L2B_SEL] ? linreg_two_b_target.second : linreg_two_b_target.first;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_q <= DVM_CTRL_RST;
      ctrl_b_q <= DVM_CTRL_RST;
      rdata_q <= 8'h00;
      on_q <= 1'b0;
    end else begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      rdata_q <= rdata_d;
      on_q <= on_d;
    end
  end

  // one ramp sequencer per supply: one code step every STEP_CYC cycles, fixed rate
  for (genvar s = 0; s < DVM_NSUP; s++) begin : g_ramp
    dvm_state_t st_d;
    logic [DVM_CODE_W-1:0] cur_d, tgt_d;
    logic [7:0] cnt_d;
    logic tick, force_def;
    always_comb begin
      force_def = (s == DVM_CORE) && core_edge;
      tick = (st_q[s] == DVM_RAMP) && (cnt_q[s] == STEP_LAST);
      done[s] = tick && (cur_q[s] == tgt_q[s]);
      st_d = st_q[s];
      cur_d = cur_q[s];
      tgt_d = tgt_q[s];
      cnt_d = cnt_q[s];
      case (st_q[s])
        DVM_IDLE: begin
          if (launch[s]) begin
            st_d = DVM_RAMP;
            tgt_d = launch_tgt[s];
            cnt_d = 8'h00;
          end
        end
        DVM_RAMP: begin
          cnt_d = tick ? 8'h00 : cnt_q[s] + 8'h01;
          if (done[s]) begin
            st_d = DVM_IDLE;
          end else if (tick) begin
            cur_d = (cur_q[s] < tgt_q[s]) ? cur_q[s] + 5'h01 : cur_q[s] - 5'h01;
          end
        end
        default: st_d = DVM_IDLE;
      endcase
      // re-enable throws away any old ramp and host target
      if (force_def) begin
        st_d = DVM_IDLE;
        cur_d = DVM_CORE_DEFAULT;
        tgt_d = DVM_CORE_DEFAULT;
        cnt_d = 8'h00;
      end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        st_q[s] <= DVM_IDLE;
        cur_q[s] <= '0;
        tgt_q[s] <= '0;
        cnt_q[s] <= 8'h00;
        busy_q[s] <= 1'b0;
      end else begin
        st_q[s] <= st_d;
        cur_q[s] <= cur_d;
        tgt_q[s] <= tgt_d;
        cnt_q[s] <= cnt_d;
        busy_q[s] <= (st_d == DVM_RAMP);
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign supply_code = cur_q;
  assign supply_busy = busy_q;
  assign core_buck_on = on_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_l2_quiet;
    !busy_q[DVM_L2] && !pin_fall;
  endsequence

  chk_l4_go_starts: assert property (wr_a && reg_wdata[A_L4_GO] && !busy_q[DVM_L4] |=> busy_q[DVM_L4])
    else $error("linreg four go did not start ramp");
  chk_sb_done_clears: assert property (done[DVM_SB] |=> !ctrl_a_q[A_SB_GO1] && !ctrl_b_q[B_SB_GO2])
    else $error("second buck go bits not cleared");
  chk_core_target_pick: assert property (launch[DVM_CORE] |=> tgt_q[DVM_CORE] == ($past(ctrl_a_d[A_CORE_SEL1]
    || ctrl_b_d[B_CORE_SEL2]) ? $past(core_target.second) : $past(core_target.first)))
    else $error("core target chosen wrongly");
  chk_sb_target_pick: assert property (launch[DVM_SB] |=> tgt_q[DVM_SB] == ($past(ctrl_a_d[A_SB_SEL1]
    || ctrl_b_d[B_SB_SEL2]) ? $past(second_buck_target.second) : $past(second_buck_target.first)))
    else $error("second buck target chosen wrongly");
  chk_l4_target_pick: assert property (launch[DVM_L4] |=> tgt_q[DVM_L4] == ($past(ctrl_a_d[A_L4_SEL])
    ? $past(linreg_four_target.second) : $past(linreg_four_target.first)))
    else $error("linreg four target chosen wrongly");
  chk_l2a_go_inert: assert property (s_l2_quiet and (wr_a || (wr_b && !reg_wdata[B_L2B_GO]))
    |=> !busy_q[DVM_L2])
    else $error("a-side go started linreg two");
  chk_l2b_go_starts: assert property (s_l2_quiet and (wr_b && reg_wdata[B_L2B_GO]) |=> busy_q[DVM_L2]
    && tgt_q[DVM_L2] == ($past(ctrl_b_d[B_L2B_SEL]) ? $past(linreg_two_b_target.second)
    : $past(linreg_two_b_target.first)))
    else $error("b-side go misbehaved");
  chk_pin_launch_l2: assert property (pin_fall && !busy_q[DVM_L2] |=> busy_q[DVM_L2]
    && tgt_q[DVM_L2] == ($past(ctrl_a_d[A_L2A_SEL2] || ctrl_b_d[B_L2A_SEL1])
    ? $past(linreg_two_a_target.second) : $past(linreg_two_a_target.first)))
    else $error("pin edge did not launch linreg two");
  chk_core_on_level: assert property ($rose(pin_s2_q) && !core_active_level ##1 !core_active_level
    |-> ##1 !core_buck_on)
    else $error("core buck not off at inactive level");
  chk_core_default: assert property (core_edge |=> supply_code[DVM_CORE] == DVM_CORE_DEFAULT
    && !supply_busy[DVM_CORE])
    else $error("core did not restart at default");
  chk_ramp_step: assert property (busy_q[DVM_L4] |=> (supply_code[DVM_L4] == $past(supply_code[DVM_L4]))
    || (supply_code[DVM_L4] == $past(supply_code[DVM_L4]) + 5'h01)
    || (supply_code[DVM_L4] == $past(supply_code[DVM_L4]) - 5'h01))
    else $error("linreg four jumped more than one code");
  chk_busy_go_frozen: assert property (busy_q[DVM_L4] && wr_a && !reg_wdata[A_L4_GO] && !done[DVM_L4]
    |=> ctrl_a_q[A_L4_GO] && busy_q[DVM_L4])
    else $error("go write disturbed a running ramp");
endmodule : dvm_ctrl

// [dvm_host.sv]
// dvm_host: host model that drives the byte register port and the target codes.
// assumes dvm_ctrl takes strobes on the rising edge of sys_clk.
`timescale 1ns/1ps
module dvm_host
  import dvm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output dvm_pair_t tgt [5]
);
  // idle port; targets 0 core, 1 second buck, 2 linreg four, 3/4 linreg two a/b
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    for (int i = 0; i < 5; i++) tgt[i] = '0;
  end
  // a target is settled in its own step, before any go byte
  task automatic set_tgt(input int idx, input logic [4:0] first, input logic [4:0] second);
    @(posedge sys_clk);
    tgt[idx] <= {second, first};
  endtask : set_tgt
  // released lines turn over so stale values are never mistaken for live ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : dvm_host

// [tb_top.sv]
// tb_top: self-checking bench for dvm_ctrl with a host model on the register port.
// assumes STEP_CYC of 2 so every ramp ends within a few dozen cycles.
`timescale 1ns/1ps
module tb_top
  import dvm_pkg::*;
  ;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b1;
  logic [7:0] d;
  wire logic reg_wr, reg_rd;
  wire logic [7:0] reg_addr, reg_wdata;
  logic [7:0] rdata;
  dvm_pair_t tgt [5];
  logic [DVM_NSUP-1:0][DVM_CODE_W-1:0] code;
  logic [DVM_NSUP-1:0] busy;
  logic on;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  localparam logic [7:0] A = DVM_ADDR_CTRL_A;
  localparam logic [7:0] B = DVM_ADDR_CTRL_B;

  always #5 sys_clk = ~sys_clk;

  dvm_host host (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .tgt(tgt));
  // short step count keeps the run small; active-low pin level throughout
  dvm_ctrl #(.STEP_CYC(2)) uut (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .core_target(tgt[0]),
    .second_buck_target(tgt[1]), .linreg_four_target(tgt[2]), .linreg_two_a_target(tgt[3]),
    .linreg_two_b_target(tgt[4]), .core_enable_pin(pin), .core_active_level(1'b0),
    .supply_code(code), .supply_busy(busy), .core_buck_on(on));

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // launch state seen right after the write, then bounded wait for ramp end
  task automatic ramp(input int idx, input logic bsy, input logic [4:0] exp);
    int n;
    n = 0;
    #1;
    chk("busy", {7'h00, bsy}, {7'h00, busy[idx]});
    while (busy[idx] !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("code", {3'h0, exp}, {3'h0, code[idx]});
  endtask : ramp

  task automatic pin_to(input logic v);
    @(posedge sys_clk);
    pin <= v;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : pin_to

  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    host.rd(A, d);
    chk("ctrl_a", 8'h00, d);
    host.rd(B, d);
    chk("ctrl_b", 8'h00, d);
    host.rd(8'h22, d);
    chk("unmapped", 8'h00, d);
    host.set_tgt(2, 5'h03, 5'h09);
    host.wr(A, 8'h40);
    ramp(DVM_L4, 1'b1, 5'h03);
    host.rd(A, d);
    chk("ctrl_a", 8'h00, d);
    host.wr(A, 8'hC0);
    host.wr(A, 8'h80);
    ramp(DVM_L4, 1'b1, 5'h09);
    host.rd(A, d);
    chk("ctrl_a", 8'h80, d);
    host.set_tgt(1, 5'h02, 5'h06);
    for (int i = 0; i < 4; i++) begin
      host.wr(A, {6'h00, i[0], 1'b0});
      host.wr(B, {6'h00, i[1], 1'b1});
      ramp(DVM_SB, 1'b1, (i == 0) ? 5'h02 : 5'h06);
    end
    host.set_tgt(0, 5'h01, 5'h1F);
    host.set_tgt(3, 5'h04, 5'h08);
    host.set_tgt(4, 5'h07, 5'h0C);
    pin_to(1'b0);
    chk("buck on", 8'h01, {7'h00, on});
    chk("core code", {3'h0, DVM_CORE_DEFAULT}, {3'h0, code[DVM_CORE]});
    ramp(DVM_L2, 1'b1, 5'h04);
    for (int i = 0; i < 4; i++) begin
      host.wr(B, {4'h0, i[1], 3'h0});
      host.wr(A, {4'h0, i[0], 3'h4});
      ramp(DVM_CORE, 1'b1, (i == 0) ? 5'h01 : 5'h1F);
    end
    host.wr(A, 8'h20);
    pin_to(1'b1);
    chk("buck on", 8'h00, {7'h00, on});
    pin_to(1'b0);
    chk("core code", {3'h0, DVM_CORE_DEFAULT}, {3'h0, code[DVM_CORE]});
    ramp(DVM_L2, 1'b1, 5'h08);
    host.wr(A, 8'h10);
    host.wr(B, 8'h10);
    ramp(DVM_L2, 1'b0, 5'h08);
    host.wr(B, 8'h40);
    ramp(DVM_L2, 1'b1, 5'h07);
    host.wr(B, 8'hC0);
    ramp(DVM_L2, 1'b1, 5'h0C);
    close_out();
  end
endmodule : tb_top
